/* logic/selftest_pkg.sv */
// types shared by the self-test block
package selftest_pkg;

  // ==========================================================
  // one access on the serial register port, already decoded
  typedef struct packed {
    logic       wr;     // one-cycle write strobe
    logic       rd;     // one-cycle read strobe
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } regReq_t;

  // ==========================================================
  // self-test sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } testState_t;

endpackage

/* logic/selftest_regs.svh */
// register offsets, field positions, reset values and timing counts of the self-test block
`ifndef SELFTEST_REGS_SVH
`define SELFTEST_REGS_SVH

// ==========================================================
// register offsets on the serial register port
`define ST_SIG_A_OFS      8'h0c
`define ST_SIG_B_OFS      8'h0d
`define ST_SIG_C_OFS      8'h0e
`define ST_SIG_D_OFS      8'h0f
`define ST_DIAG_CTRL_OFS  8'h10
`define ST_SOFT_RST_OFS   8'h3a

// ==========================================================
// field positions and values
`define ST_DIAG_LAUNCH_BIT 0
`define ST_SOFT_RST_KEY    8'h5a
`define ST_SIG_RESET       32'h0000_0000
`define ST_RDATA_RESET     8'h00

// ==========================================================
// imaging array geometry
`define ST_ARRAY_SIDE      5'd19
`define ST_ARRAY_LAST      9'd360

// ==========================================================
// timing: test time in ms, clock in Hz, cycles derived
`define ST_TEST_TIME_MS    250
`define ST_CLK_HZ          50000000
`define ST_TEST_CYCLES     ((`ST_CLK_HZ / 1000) * `ST_TEST_TIME_MS)

`endif

/* logic/sensor_self_test.sv */
// self-test sequencer, signature result registers and pixel scan of the imaging array
`timescale 1ns/1ps
`include "selftest_regs.svh"
module sensor_self_test #(
  parameter int TEST_CYCLES = `ST_TEST_CYCLES,  // shorten for simulation
  parameter int CNT_W       = 24                // wide enough for TEST_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire selftest_pkg::regReq_t   regReq,    // decoded serial port access
  output logic      [7:0]              regRdata,  // read answer, one cycle after rd
  output logic                         testBusy,  // self-test running
  output logic      [8:0]              pixAddr,   // pixel being scanned
  input  wire logic [7:0]              pixData    // pixel value at pixAddr
);

  // ==========================================================
  // state
  selftest_pkg::testState_t state_q, state_d;  // sequencer state
  logic [CNT_W-1:0] runCnt_q, runCnt_d;        // cycles spent in test
  logic [4:0]       row_q, row_d;              // scan row, 0 is top
  logic [4:0]       col_q, col_d;              // scan column, 0 is left
  logic [8:0]       pixAddr_q, pixAddr_d;      // registered pixel address
  logic [31:0]      sig_q, sig_d;              // held signature bytes
  logic [7:0]       rdata_q, rdata_d;          // read data register
  logic [31:0]      misrSig;                   // running compaction
  logic             launch;                    // launch write accepted
  logic             softRst;                   // soft reset write accepted
  logic             runLast;                   // final cycle of test
  logic             scanEn;                    // fold a pixel this cycle

  localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(TEST_CYCLES - 1);

  // ==========================================================
  // write decode; every access is ignored while the test runs,
  // since the host is not supposed to touch the port then
  always_comb begin
    launch  = 1'b0;
    softRst = 1'b0;
    if (regReq.wr && state_q == selftest_pkg::ST_IDLE) begin
      if (regReq.addr == `ST_DIAG_CTRL_OFS) begin
        launch = regReq.wdata[`ST_DIAG_LAUNCH_BIT];
      end else if (regReq.addr == `ST_SOFT_RST_OFS) begin
        softRst = (regReq.wdata == `ST_SOFT_RST_KEY);
      end
    end
  end

  assign runLast = (state_q == selftest_pkg::ST_RUN) && (runCnt_q == RUN_LAST);
  assign scanEn  = (state_q == selftest_pkg::ST_RUN);

  // ==========================================================
  // sequencer: idle until launched, run a fixed number of cycles
  always_comb begin
    state_d  = state_q;
    runCnt_d = runCnt_q;
    case (state_q)
      selftest_pkg::ST_IDLE: begin
        runCnt_d = '0;
        if (launch) begin
          state_d = selftest_pkg::ST_RUN;
        end
      end
      selftest_pkg::ST_RUN: begin
        runCnt_d = runCnt_q + 1'b1;
        if (runLast) begin
          state_d  = selftest_pkg::ST_IDLE;
          runCnt_d = '0;
        end
      end
      default: begin
        state_d = selftest_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // pixel scan: row by row from top-left, wrapping after 361 pixels
  always_comb begin
    row_d = row_q;
    col_d = col_q;
    if (launch || softRst) begin
      row_d = '0;
      col_d = '0;
    end else if (scanEn) begin
      if (col_q == `ST_ARRAY_SIDE - 5'd1) begin
        col_d = '0;
        row_d = (row_q == `ST_ARRAY_SIDE - 5'd1) ? 5'd0 : row_q + 5'd1;
      end else begin
        col_d = col_q + 5'd1;
      end
    end
    // top-left seen through the lens is the highest address
    pixAddr_d = `ST_ARRAY_LAST - (9'(row_d) * 9'(`ST_ARRAY_SIDE) + 9'(col_d));
  end

  // ==========================================================
  // signature hold: cleared on launch or soft reset, loaded at the end
  always_comb begin
    sig_d = sig_q;
    if (launch || softRst) begin
      sig_d = `ST_SIG_RESET;
    end else if (runLast) begin
      sig_d = misrSig;
    end
    // otherwise held untouched until relaunch, soft reset or reset
  end

  // ==========================================================
  // read decode; write-only and unmapped offsets answer zero
  always_comb begin
    rdata_d = `ST_RDATA_RESET;
    if (regReq.rd && state_q == selftest_pkg::ST_IDLE) begin
      if (regReq.addr == `ST_SIG_A_OFS) begin
        rdata_d = sig_q[7:0];
      end else if (regReq.addr == `ST_SIG_B_OFS) begin
        rdata_d = sig_q[15:8];
      end else if (regReq.addr == `ST_SIG_C_OFS) begin
        rdata_d = sig_q[23:16];
      end else if (regReq.addr == `ST_SIG_D_OFS) begin
        rdata_d = sig_q[31:24];
      end else begin
        rdata_d = `ST_RDATA_RESET;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= selftest_pkg::ST_IDLE;
      runCnt_q  <= '0;
      row_q     <= '0;
      col_q     <= '0;
      pixAddr_q <= `ST_ARRAY_LAST;
      sig_q     <= `ST_SIG_RESET;
      rdata_q   <= `ST_RDATA_RESET;
    end else begin
      state_q   <= state_d;
      runCnt_q  <= runCnt_d;
      row_q     <= row_d;
      col_q     <= col_d;
      pixAddr_q <= pixAddr_d;
      sig_q     <= sig_d;
      rdata_q   <= rdata_d;
    end
  end

  // ==========================================================
  // signature compaction of the pixel stream
  sig_misr #(
    .DATA_W (8)
  ) uMisr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clear    (launch || softRst),
    .enable   (scanEn),
    .dataIn   (pixData),
    .sig      (misrSig)
  );

  assign regRdata = rdata_q;
  assign testBusy = (state_q == selftest_pkg::ST_RUN);
  assign pixAddr  = pixAddr_q;

  // ==========================================================
  // checks
  sequence seqLaunch;
    regReq.wr && !testBusy && regReq.addr == `ST_DIAG_CTRL_OFS && regReq.wdata[0];
  endsequence

  sequence seqIdleRead(logic [7:0] a);
    regReq.rd && !testBusy && regReq.addr == a;
  endsequence

  AST_LAUNCH_RUNS: assert property (@(posedge core_clk) disable iff (!rst_b)
    seqLaunch |=> testBusy && runCnt_q == '0 && sig_q == '0)
    else $error("launch did not start the test");

  AST_ZERO_NO_LAUNCH: assert property (@(posedge core_clk) disable iff (!rst_b)
    (regReq.wr && !testBusy && regReq.addr == `ST_DIAG_CTRL_OFS && !regReq.wdata[0])
      |=> !testBusy)
    else $error("zero write started the test");

  AST_RUN_LENGTH: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(testBusy) |-> $past(runCnt_q) == RUN_LAST && sig_q == $past(misrSig))
    else $error("test ended at the wrong cycle or lost its signature");

  AST_READ_A: assert property (@(posedge core_clk) disable iff (!rst_b)
    seqIdleRead(`ST_SIG_A_OFS) |=> regRdata == $past(sig_q[7:0]))
    else $error("first signature byte read wrong");

  AST_READ_B: assert property (@(posedge core_clk) disable iff (!rst_b)
    seqIdleRead(`ST_SIG_B_OFS) |=> regRdata == $past(sig_q[15:8]))
    else $error("second signature byte read wrong");

  AST_READ_C: assert property (@(posedge core_clk) disable iff (!rst_b)
    seqIdleRead(`ST_SIG_C_OFS) |=> regRdata == $past(sig_q[23:16]))
    else $error("third signature byte read wrong");

  AST_READ_D: assert property (@(posedge core_clk) disable iff (!rst_b)
    seqIdleRead(`ST_SIG_D_OFS) |=> regRdata == $past(sig_q[31:24]))
    else $error("fourth signature byte read wrong");

  AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (regReq.wr && !testBusy && regReq.addr == `ST_SOFT_RST_OFS && regReq.wdata == 8'h5a)
      |=> !testBusy && sig_q == '0 && pixAddr == 9'h168)
    else $error("soft reset did not clear the block");

  AST_SIG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!testBusy && !launch && !softRst) |=> $stable(sig_q))
    else $error("signature changed while idle");

  AST_PIXEL_MAP: assert property (@(posedge core_clk) disable iff (!rst_b)
    // the run must outlast the wrap, or the scan stops before the second step
    (testBusy && !runLast && row_q == 5'd18 && col_q == 5'd18)
      |=> pixAddr == 9'h168 ##1 pixAddr == 9'h167)
    else $error("pixel scan orientation wrong");

endmodule

/* logic/sig_misr.sv */
// 32-bit multiple-input signature register that compacts the pixel stream
`timescale 1ns/1ps
`include "selftest_regs.svh"
module sig_misr #(
  parameter int DATA_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              clear,     // restart from zero
  input  wire logic              enable,    // fold dataIn this cycle
  input  wire logic [DATA_W-1:0] dataIn,    // pixel word
  output logic      [31:0]       sig        // running signature, registered
);

  logic [31:0] sig_q;  // signature state
  logic [31:0] sig_d;  // next signature

  // ==========================================================
  // next value: shift with feedback taps, fold data into low bits
  always_comb begin
    sig_d = sig_q;
    if (clear) begin
      sig_d = `ST_SIG_RESET;
    end else if (enable) begin
      // taps of a maximal 32-bit polynomial keep aliasing rare
      sig_d = {sig_q[30:0], sig_q[31] ^ sig_q[21] ^ sig_q[1] ^ sig_q[0]};
      sig_d[DATA_W-1:0] = sig_d[DATA_W-1:0] ^ dataIn;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_q <= `ST_SIG_RESET;
    end else begin
      sig_q <= sig_d;
    end
  end

  assign sig = sig_q;

endmodule

/* tb/pixel_array_model.sv */
// pixel array model that answers the scan port of the self-test sequencer
`timescale 1ns/1ps
module pixel_array_model (
  input  wire logic [8:0] pixAddr,  // address the sequencer is scanning
  input  wire logic [7:0] scene,    // bench-chosen scene, folded into every pixel
  output logic      [7:0] pixData   // pixel value, combinational like an array read
);
  // ==========================================================
  // scene: neighbours differ, so a wrong scan order or a skipped pixel moves the signature
  always_comb begin
    pixData = pixAddr[7:0] ^ {pixAddr[8], 7'h00} ^ scene;
  end
endmodule

/* tb/test_sensor_self_test.sv */
// self-checking bench for the self-test sequencer and its signature registers
`timescale 1ns/1ps
`include "selftest_regs.svh"
`define CHK(got, exp) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    errTotal++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module test_sensor_self_test;
  // ==========================================================
  // signals and settings
  localparam int TC = 400;                 // shortened test time, still more than one frame scan
  localparam logic [15:0] CFG [10] = '{16'h29c1, 16'h1159, 16'h60ff, 16'h6188, 16'h72aa,
                                       16'h63c4, 16'h7520, 16'h7605, 16'h7c04, 16'h7eff};
  logic                  core_clk;         // 50 MHz core clock
  logic                  rst_b;            // active-low reset
  selftest_pkg::regReq_t regReq;           // decoded host access
  logic [7:0]            regRdata;         // read answer
  logic                  testBusy;         // test running
  logic [8:0]            pixAddr;          // scanned pixel
  logic [7:0]            pixData;          // pixel value
  logic [7:0]            scene;            // scene shown to the array
  logic [31:0]           sigA;             // signature kept for comparison
  logic [31:0]           sigB;             // signature read back later
  logic [7:0]            rdVal;            // single read result
  int                    errTotal = 0;     // mismatches
  int                    nTests = 0;       // comparisons
  int                    nBusy;            // cycles seen busy

  // ==========================================================
  // design and far side
  sensor_self_test #(.TEST_CYCLES(TC), .CNT_W(24)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
    .testBusy(testBusy), .pixAddr(pixAddr), .pixData(pixData));
  pixel_array_model pixels (.pixAddr(pixAddr), .scene(scene), .pixData(pixData));

  // ==========================================================
  // clock: free running, one inversion each half period
  always #10 core_clk = ~core_clk;

  // ==========================================================
  // host access tasks; strobes are one-cycle pulses, so an idle cycle separates calls
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) regReq <= {1'b1, 1'b0, a, d};
    @(posedge core_clk) regReq <= '0;
    #1;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) regReq <= {1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) regReq <= '0;
    #1 d = regRdata;
  endtask
  task automatic rdSig(output logic [31:0] s);
    rdReg(`ST_SIG_A_OFS, s[7:0]);
    rdReg(`ST_SIG_B_OFS, s[15:8]);
    rdReg(`ST_SIG_C_OFS, s[23:16]);
    rdReg(`ST_SIG_D_OFS, s[31:24]);
  endtask
  // launch, then stay off the port and count busy cycles while watching the scan order
  task automatic runTest();
    wrReg(`ST_DIAG_CTRL_OFS, 8'h01);
    `CHK(testBusy, 1'b1)
    nBusy = 0;
    while (testBusy === 1'b1 && nBusy < 10 * TC) begin
      if (nBusy == 0) `CHK(pixAddr, 9'h168)
      if (nBusy == 1) `CHK(pixAddr, 9'h167)
      if (nBusy == 19) `CHK(pixAddr, 9'h155)
      if (nBusy == 360) `CHK(pixAddr, 9'h000)
      @(posedge core_clk);
      #1 nBusy++;
    end
    `CHK(nBusy, TC)
  endtask

  // ==========================================================
  // verdict, shared by the main sequence and the watchdog
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // watchdog: three runs of TC cycles plus a few hundred port cycles, wide margin
  initial begin
    repeat (20 * TC) @(posedge core_clk);
    errTotal++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    regReq = '0;
    scene = 8'h3c;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    `CHK({testBusy, regRdata, pixAddr}, {1'b0, 8'h00, 9'h168})
    // power-up done: soft reset, configuration, then a write to a result byte
    wrReg(`ST_SOFT_RST_OFS, `ST_SOFT_RST_KEY);
    for (int i = 0; i < 10; i++) wrReg(CFG[i][15:8], CFG[i][7:0]);
    wrReg(`ST_SIG_A_OFS, 8'hff);
    rdSig(sigA);
    `CHK(sigA, `ST_SIG_RESET)
    // bit 0 clear must not launch, whatever the reserved bits hold
    wrReg(`ST_DIAG_CTRL_OFS, 8'hfe);
    `CHK(testBusy, 1'b0)
    runTest();
    rdSig(sigA);
    `CHK(sigA != 32'h0, 1'b1)
    repeat (30) @(posedge core_clk);
    rdSig(sigB);
    `CHK(sigB, sigA)
    rdReg(`ST_DIAG_CTRL_OFS, rdVal);
    `CHK(rdVal, 8'h00)
    rdReg(8'h55, rdVal);
    `CHK(rdVal, 8'h00)
    // redo the preparation, then the same scene repeats its signature
    wrReg(`ST_SOFT_RST_OFS, `ST_SOFT_RST_KEY);
    for (int i = 0; i < 10; i++) wrReg(CFG[i][15:8], CFG[i][7:0]);
    runTest();
    rdSig(sigB);
    `CHK(sigB, sigA)
    @(posedge core_clk) scene <= 8'hc3;
    runTest();
    rdSig(sigB);
    `CHK(sigB !== sigA, 1'b1)
    // a wrong key leaves the result, the right key clears it
    wrReg(`ST_SOFT_RST_OFS, 8'h5b);
    rdSig(sigA);
    `CHK(sigA, sigB)
    wrReg(`ST_SOFT_RST_OFS, `ST_SOFT_RST_KEY);
    rdSig(sigA);
    `CHK(sigA, `ST_SIG_RESET)
    // reset in mid-test stops the run and leaves no signature
    wrReg(`ST_DIAG_CTRL_OFS, 8'h01);
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b0;
    // hold two edges so no sampled edge of testBusy straddles the release
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    `CHK({testBusy, pixAddr}, {1'b0, 9'h168})
    rdSig(sigA);
    `CHK(sigA, `ST_SIG_RESET)
    conclude();
  end
endmodule
